/* hw/psw_flags.sv */
// Program status word with arithmetic flag update and bank select
//
// How it works
// (RQ1) Carry is set by a carry out on add or borrow on subtract, else cleared by arithmetic.
// (RQ2) Half carry is set by a carry into or borrow from the upper nibble, else cleared.
// (RQ3) Two user flags hold whatever software writes and hardware never changes them.
// (RQ4) Bank select picks one of four eight-byte register banks, code 00 lowest.
// (RQ5) Overflow is set by a signed sign change on add, add-with-carry or subtract-with-borrow.
// (RQ6) Overflow is set when a multiply product exceeds 255.
// (RQ7) Overflow is set when a divide has a zero divisor.
// (RQ8) Overflow is cleared by those five instructions when no overflow condition occurs.
// (RQ9) The read-only parity bit is high when the accumulator holds an odd count of ones.
// (RQ10) The word sits at special function address 0xd0 and allows byte and single-bit access.
// (RQ11) A software write and an instruction update in one cycle resolve to the instruction in the bits it updates; other bits take the write.
`timescale 1ns/1ns

module psw_flags
	import psw_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire psw_alu_req_s i_alu,
	input wire psw_sfr_req_s i_sfr,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_acc,
	output logic [7:0] o_psw,
	output logic [7:0] o_rdata,
	output logic [7:0] o_bank_base
);

	// ----------------------------------------
	// Arithmetic helpers
	// ----------------------------------------
	function automatic logic [8:0] psw_add9(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		psw_add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
	endfunction

	function automatic logic [4:0] psw_add5(input logic [3:0] a, input logic [3:0] b,
		input logic ci);
		psw_add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
	endfunction

	function automatic logic [7:0] psw_bank(input logic [1:0] rs);
		psw_bank = {3'b000, rs, 3'b000};
	endfunction

	psw_state_s st_r;
	psw_state_s st_nxt;

	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [8:0] dif9;
	logic [4:0] dif5;
	logic [15:0] prod;
	logic add_with_carry_in;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		add_with_carry_in = (i_alu.op == PSW_OP_ADD_WITH_CARRY) ? st_r.psw[PSW_CY_BIT] : 1'b0;
		sum9 = psw_add9(i_alu.a, i_alu.b, add_with_carry_in);
		sum5 = psw_add5(i_alu.a[3:0], i_alu.b[3:0], add_with_carry_in);
		// Subtract as a + ~b + ~borrow; borrow is the inverted carry
		dif9 = psw_add9(i_alu.a, ~i_alu.b, ~st_r.psw[PSW_CY_BIT]);
		dif5 = psw_add5(i_alu.a[3:0], ~i_alu.b[3:0], ~st_r.psw[PSW_CY_BIT]);
		prod = {8'h00, i_alu.a} * {8'h00, i_alu.b};
		// Software write first so an instruction update in the same cycle wins
		if (i_sfr.wr && i_sfr.addr == PSW_SFR_ADDR) begin // RQ10
			if (i_sfr.bit_op) begin
				st_nxt.psw[i_bit_sel] = i_sfr.wdata[0];
			end else begin
				st_nxt.psw = i_sfr.wdata;
			end
		end
		if (i_alu.valid) begin // RQ11
			case (i_alu.op)
				PSW_OP_ADD, PSW_OP_ADD_WITH_CARRY: begin
					st_nxt.psw[PSW_CY_BIT] = sum9[8]; // RQ1
					st_nxt.psw[PSW_AC_BIT] = sum5[4]; // RQ2
					st_nxt.psw[PSW_OV_BIT] = (i_alu.a[7] == i_alu.b[7]) &&
						(sum9[7] != i_alu.a[7]); // RQ5 RQ8
				end
				PSW_OP_SUBTRACT_WITH_BORROW: begin
					st_nxt.psw[PSW_CY_BIT] = ~dif9[8]; // RQ1
					st_nxt.psw[PSW_AC_BIT] = ~dif5[4]; // RQ2
					st_nxt.psw[PSW_OV_BIT] = (i_alu.a[7] != i_alu.b[7]) &&
						(dif9[7] != i_alu.a[7]); // RQ5 RQ8
				end
				PSW_OP_MUL: begin
					st_nxt.psw[PSW_CY_BIT] = 1'b0; // RQ1
					st_nxt.psw[PSW_OV_BIT] = prod[15:8] != 8'h00; // RQ6 RQ8
				end
				PSW_OP_DIV: begin
					st_nxt.psw[PSW_CY_BIT] = 1'b0; // RQ1
					st_nxt.psw[PSW_OV_BIT] = i_alu.b == 8'h00; // RQ7 RQ8
				end
				PSW_OP_CARRY: begin
					st_nxt.psw[PSW_CY_BIT] = i_alu.carry_val;
				end
				default: begin
				end
			endcase
		end
		// User flags touched only by software above; parity tracks the accumulator
		st_nxt.psw[PSW_PAR_BIT] = ^i_acc; // RQ9 RQ3
		st_nxt.rdata = st_nxt.psw;
		st_nxt.bank_base = psw_bank(st_nxt.psw[PSW_RS_LO+1:PSW_RS_LO]); // RQ4
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			st_r <= '{psw: PSW_RESET, rdata: PSW_RESET, bank_base: 8'h00};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_psw = st_r.psw;
	assign o_rdata = st_r.rdata;
	assign o_bank_base = st_r.bank_base;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_add_carry;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD |=> o_psw[7] == $past(sum9[8]);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong after add"); // RQ1

	property p_add_half;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD |=>
			o_psw[6] == ($past(i_alu.a[3:0]) + $past(i_alu.b[3:0]) > 5'd15);
	endproperty
	a_add_half: assert property (p_add_half) else $error("half carry wrong after add"); // RQ2

	property p_user_hold;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!(i_sfr.wr && i_sfr.addr == PSW_SFR_ADDR) |=> $stable({o_psw[5], o_psw[1]});
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("user flag changed"); // RQ3

	property p_bank;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		##1 o_bank_base == PSW_BANK_SIZE * o_psw[4:3];
	endproperty
	a_bank: assert property (p_bank) else $error("bank base mismatch"); // RQ4

	property p_add_ov;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD && i_alu.a == 8'h7f && i_alu.b == 8'h01
		|=> o_psw[2];
	endproperty
	a_add_ov: assert property (p_add_ov) else $error("overflow missed on add"); // RQ5

	property p_mul_ov;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_MUL |=>
			o_psw[2] == ($past(prod) > {8'h00, PSW_MUL_LIMIT}) && !o_psw[7];
	endproperty
	a_mul_ov: assert property (p_mul_ov) else $error("multiply overflow wrong"); // RQ6

	property p_div_ov;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_DIV |=> o_psw[2] == ($past(i_alu.b) == 8'h00);
	endproperty
	a_div_ov: assert property (p_div_ov) else $error("divide overflow wrong"); // RQ7

	property p_parity;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		##1 o_psw[0] == ^$past(i_acc);
	endproperty
	a_parity: assert property (p_parity) else $error("parity mismatch"); // RQ9

	property p_byte_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_sfr.wr && !i_sfr.bit_op && i_sfr.addr == PSW_SFR_ADDR && !i_alu.valid |=>
			(o_psw & PSW_WR_MASK) == ($past(i_sfr.wdata) & PSW_WR_MASK);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write lost"); // RQ10

	property p_alu_wins;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_DIV && i_sfr.wr && i_sfr.addr == PSW_SFR_ADDR
		|=> !o_psw[7];
	endproperty
	a_alu_wins: assert property (p_alu_wins) else $error("write beat instruction"); // RQ11

	property p_add_with_carry_carry;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD_WITH_CARRY |=>
			o_psw[7] == ({1'b0, $past(i_alu.a)} + {1'b0, $past(i_alu.b)} +
			{8'h00, $past(o_psw[7])} > 9'h0ff);
	endproperty
	a_add_with_carry_carry: assert property (p_add_with_carry_carry) else $error("carry wrong after add_with_carry"); // RQ1

	property p_subtract_with_borrow_carry;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_SUBTRACT_WITH_BORROW |=>
			o_psw[7] == ({1'b0, $past(i_alu.a)} < {1'b0, $past(i_alu.b)} +
			{8'h00, $past(o_psw[7])});
	endproperty
	a_subtract_with_borrow_carry: assert property (p_subtract_with_borrow_carry) else $error("borrow wrong after subtract_with_borrow"); // RQ1

	property p_add_with_carry_half;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD_WITH_CARRY |=>
			o_psw[6] == ({1'b0, $past(i_alu.a[3:0])} + {1'b0, $past(i_alu.b[3:0])} +
			{4'h0, $past(o_psw[7])} > 5'h0f);
	endproperty
	a_add_with_carry_half: assert property (p_add_with_carry_half) else $error("half carry wrong after add_with_carry"); // RQ2

	property p_subtract_with_borrow_half;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_SUBTRACT_WITH_BORROW |=>
			o_psw[6] == ({1'b0, $past(i_alu.a[3:0])} < {1'b0, $past(i_alu.b[3:0])} +
			{4'h0, $past(o_psw[7])});
	endproperty
	a_subtract_with_borrow_half: assert property (p_subtract_with_borrow_half) else $error("half borrow wrong after subtract_with_borrow"); // RQ2

	property p_add_with_carry_ov;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD_WITH_CARRY |=>
			o_psw[2] == ($past(i_alu.a[7]) == $past(i_alu.b[7]) && $past(sum9[7]) != $past(i_alu.a[7]));
	endproperty
	a_add_with_carry_ov: assert property (p_add_with_carry_ov) else $error("overflow wrong after add_with_carry"); // RQ5

	property p_subtract_with_borrow_ov;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_SUBTRACT_WITH_BORROW |=>
			o_psw[2] == ($past(i_alu.a[7]) != $past(i_alu.b[7]) && $past(dif9[7]) != $past(i_alu.a[7]));
	endproperty
	a_subtract_with_borrow_ov: assert property (p_subtract_with_borrow_ov) else $error("overflow wrong after subtract_with_borrow"); // RQ5

	property p_add_ov_clear;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD && i_alu.a == 8'h00 && i_alu.b == 8'h00
		|=> !o_psw[2];
	endproperty
	a_add_ov_clear: assert property (p_add_ov_clear) else $error("overflow not cleared"); // RQ8

	// Multiply and divide leave the half carry alone
	property p_muldiv_half;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && (i_alu.op == PSW_OP_MUL || i_alu.op == PSW_OP_DIV) &&
		!(i_sfr.wr && i_sfr.addr == PSW_SFR_ADDR) |=> o_psw[6] == $past(o_psw[6]);
	endproperty
	a_muldiv_half: assert property (p_muldiv_half) else $error("half carry moved"); // RQ2

	property p_div_carry;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_DIV |=> !o_psw[7];
	endproperty
	a_div_carry: assert property (p_div_carry) else $error("carry not cleared by divide"); // RQ1

	property p_carry_load;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_CARRY |=> o_psw[7] == $past(i_alu.carry_val);
	endproperty
	a_carry_load: assert property (p_carry_load) else $error("carry load lost"); // RQ1

	property p_bit_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_sfr.wr && i_sfr.bit_op && i_sfr.addr == PSW_SFR_ADDR && !i_alu.valid &&
		i_bit_sel != 3'h0 |=> o_psw[$past(i_bit_sel)] == $past(i_sfr.wdata[0]);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit write lost"); // RQ10

	// A write to bit 0 must not stick; parity keeps following the accumulator
	property p_parity_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_sfr.wr && i_sfr.bit_op && i_sfr.addr == PSW_SFR_ADDR && i_bit_sel == 3'h0
		|=> o_psw[0] == ^$past(i_acc);
	endproperty
	a_parity_write: assert property (p_parity_write) else $error("parity bit written"); // RQ9

	property p_other_addr;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_sfr.wr && i_sfr.addr != PSW_SFR_ADDR && !i_alu.valid |=> o_psw[7:1] == $past(o_psw[7:1]);
	endproperty
	a_other_addr: assert property (p_other_addr) else $error("foreign write taken"); // RQ10

	property p_idle_hold;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(!i_alu.valid || i_alu.op == PSW_OP_NONE) && !i_sfr.wr |=> o_psw[7:1] == $past(o_psw[7:1]);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("word changed while idle"); // RQ3

	property p_rdata;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_rdata == o_psw;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data differs from word"); // RQ10

	property p_bank_write;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_sfr.wr && !i_sfr.bit_op && i_sfr.addr == PSW_SFR_ADDR && !i_alu.valid |=>
			o_bank_base == PSW_BANK_SIZE * $past(i_sfr.wdata[4:3]);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank base not following write"); // RQ4

	// Bits the instruction does not touch still take the write
	property p_write_keeps;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		i_alu.valid && i_alu.op == PSW_OP_ADD && i_sfr.wr && !i_sfr.bit_op &&
		i_sfr.addr == PSW_SFR_ADDR |=> o_psw[5:3] == $past(i_sfr.wdata[5:3]) &&
			o_psw[1] == $past(i_sfr.wdata[1]);
	endproperty
	a_write_keeps: assert property (p_write_keeps) else $error("write lost beside instruction"); // RQ11

	property p_reset_clear;
		@(posedge i_ref_clk)
		!i_nrst |=> o_psw == PSW_RESET && o_bank_base == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong"); // RQ10

endmodule

/* hw/psw_pkg.sv */
// Program status word package: address, field layout, reset value, carriers
package psw_pkg;

	localparam logic [7:0] PSW_SFR_ADDR = 8'hd0;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam int PSW_CY_BIT = 7;
	localparam int PSW_AC_BIT = 6;
	localparam int PSW_F0_BIT = 5;
	localparam int PSW_RS_LO = 3;
	localparam int PSW_OV_BIT = 2;
	localparam int PSW_F1_BIT = 1;
	localparam int PSW_PAR_BIT = 0;
	localparam logic [7:0] PSW_WR_MASK = 8'hfe;
	localparam logic [7:0] PSW_BANK_SIZE = 8'h08;
	localparam logic [7:0] PSW_MUL_LIMIT = 8'hff;

	typedef enum logic [2:0] {
		PSW_OP_NONE,
		PSW_OP_ADD,
		PSW_OP_ADD_WITH_CARRY,
		PSW_OP_SUBTRACT_WITH_BORROW,
		PSW_OP_MUL,
		PSW_OP_DIV,
		PSW_OP_CARRY
	} psw_op_e;

	// One flag update from the arithmetic unit
	typedef struct packed {
		logic valid;
		psw_op_e op;
		logic [7:0] a;
		logic [7:0] b;
		logic carry_val;
	} psw_alu_req_s;

	// Special function register access
	typedef struct packed {
		logic wr;
		logic bit_op;
		logic [7:0] addr;
		logic [7:0] wdata;
	} psw_sfr_req_s;

	typedef struct packed {
		logic [7:0] psw;
		logic [7:0] rdata;
		logic [7:0] bank_base;
	} psw_state_s;

endpackage

/* verif/psw_core_model.sv */
// Arithmetic unit model that issues flag updates
`timescale 1ns/1ns
module psw_core_model
	import psw_pkg::*;
(
	input wire logic i_go,
	input wire psw_op_e i_op,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_cv,
	output psw_alu_req_s o_alu
);
	// ------
	// Issue
	// ------
	// Idle operands are inverted so a stale value is never taken for a live one
	assign o_alu = i_go ? '{1'b1, i_op, i_a, i_b, i_cv} : '{1'b0, PSW_OP_NONE, ~i_a, ~i_b, 1'b0};
endmodule

/* verif/testbench.sv */
// Self-checking bench for the status word
`timescale 1ns/1ns
module testbench
	import psw_pkg::*;
;
	// ------
	// Setup
	// ------
	logic clk = 0, nrst = 0, go = 0, cv = 0, pend = 0, ci;
	psw_op_e op = PSW_OP_NONE;
	logic [7:0] a = 0, b = 0, acc = 0, exp_r = 0, psw, rd, base;
	logic [8:0] r;
	logic [2:0] sel = 0;
	psw_sfr_req_s sfr = '0;
	psw_alu_req_s alu;
	logic [7:0] q[$];
	int errors = 0, checked = 0, seed = 32'h0801da6e, i;
	always #5 clk = ~clk;
	psw_core_model model (.i_go(go), .i_op(op), .i_a(a), .i_b(b), .i_cv(cv), .o_alu(alu));
	psw_flags dut (.i_ref_clk(clk), .i_nrst(nrst), .i_alu(alu), .i_sfr(sfr), .i_bit_sel(sel),
		.i_acc(acc), .o_psw(psw), .o_rdata(rd), .o_bank_base(base));
	task chk(input logic [23:0] seen, input logic [23:0] want);
		checked++;
		if (seen !== want) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task end_sim;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Requests stay driven until the next req or idle call, so calls in a row go back to back
	task req(input logic v, input psw_op_e o, input logic [7:0] x, y, input logic w, bo,
		input logic [7:0] ad, wd, input logic [2:0] s);
		@(posedge clk);
		#1;
		go = v; op = o; a = x; b = y; cv = s[0]; sel = s;
		sfr = '{w, bo, ad, wd};
		// Carry in is the flag as it stood before any write in the same cycle
		ci = o != PSW_OP_ADD && exp_r[7];
		if (w && ad == PSW_SFR_ADDR && bo && s != 0) exp_r[s] = wd[0];
		if (w && ad == PSW_SFR_ADDR && !bo) exp_r[7:1] = wd[7:1];
		if (v && o inside {PSW_OP_ADD, PSW_OP_ADD_WITH_CARRY, PSW_OP_SUBTRACT_WITH_BORROW}) begin
			if (o == PSW_OP_SUBTRACT_WITH_BORROW) begin
				r = x - y - ci;
				exp_r[6] = x[3:0] < {1'b0, y[3:0]} + ci;
				exp_r[2] = x[7] != y[7] && r[7] != x[7];
			end else begin
				r = x + y + ci;
				exp_r[6] = {1'b0, x[3:0]} + y[3:0] + ci > 15;
				exp_r[2] = x[7] == y[7] && r[7] != x[7];
			end
			exp_r[7] = r[8];
		end
		if (v && o inside {PSW_OP_MUL, PSW_OP_DIV}) begin
			exp_r[7] = 0;
			exp_r[2] = o == PSW_OP_MUL ? x * y > 255 : y == 0;
		end
		if (v && o == PSW_OP_CARRY) exp_r[7] = s[0];
		q.push_back({exp_r[7:1], ^acc});
	endtask
	task idle;
		@(posedge clk);
		#1;
		go = 0;
		sfr.wr = 0;
	endtask
	// ------
	// Monitor
	// ------
	always @(posedge clk) begin
		#2;
		if (pend) chk({psw, rd, base}, {q[0], q[0], 3'b0, q[0][4:3], 3'b0});
		if (pend) void'(q.pop_front());
		pend = alu.valid | sfr.wr;
	end
	initial begin
		#100000;
		errors++;
		end_sim;
	end
	// ------
	// Scenarios
	// ------
	initial begin
		repeat (3) @(posedge clk);
		#1 nrst = 1;
		#2 chk({psw, rd, base}, 24'h000000);
		req(1, PSW_OP_ADD, 8'h7f, 8'h01, 0, 0, 0, 0, 0);
		req(1, PSW_OP_MUL, 8'h10, 8'h10, 0, 0, 0, 0, 0);
		req(1, PSW_OP_MUL, 8'h0f, 8'h11, 0, 0, 0, 0, 0);
		req(1, PSW_OP_DIV, 8'h05, 8'h00, 0, 0, 0, 0, 0);
		req(1, PSW_OP_DIV, 8'h05, 8'h02, 0, 0, 0, 0, 0);
		for (i = 0; i < 4; i++) req(0, PSW_OP_NONE, 0, 0, 1, 0, PSW_SFR_ADDR, 8'(i << 3), 0);
		for (i = 0; i < 8; i++) req(0, PSW_OP_NONE, 0, 0, 1, 1, PSW_SFR_ADDR, 8'($random(seed)), 3'(i));
		req(0, PSW_OP_NONE, 0, 0, 1, 0, 8'hd1, 8'hff, 0);
		req(1, PSW_OP_ADD, 0, 0, 1, 0, PSW_SFR_ADDR, 8'hff, 0);
		req(1, PSW_OP_DIV, 8'h05, 8'h00, 1, 0, PSW_SFR_ADDR, 8'hff, 0);
		req(1, PSW_OP_NONE, 8'hff, 8'hff, 0, 0, 0, 0, 0);
		idle;
		acc = 8'($random(seed));
		repeat (2) @(posedge clk);
		for (i = 0; i < 60; i++) req(1, psw_op_e'(1 + i % 6), 8'($random(seed)), 8'($random(seed)),
			0, 0, 0, 0, 3'($random(seed)));
		idle;
		repeat (2) @(posedge clk);
		end_sim;
	end
endmodule
